//--- hdl/sdr_link_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two-flop synchroniser with edge detection
// ----------------------------------------------------------------
module sdr_link_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] meta_reg; // First stage, read only by sync_reg
  logic [WIDTH-1:0] sync_reg; // Safe level
  logic [WIDTH-1:0] last_reg; // Previous safe level for edges

  // Chain of three flops
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
      last_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign o_level = sync_reg;
  assign o_rise = sync_reg & ~last_reg;
  assign o_fall = ~sync_reg & last_reg;
endmodule : sdr_link_sync

//--- hdl/sdr_top.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "sdr_defines.svh"
// What this block does
// - Two-bit restart cause field recorded
// - Read-only read of diagnostics clears restart
// - Leaving sleep or fail-safe clears restart
// - Three-bit fallback cause code stored
// - Fallback off write zeroes fallback cause
// - Three-bit strap readout, top bit development
// - Development mode: watchdog failure causes nothing
// - Normal command answers previous request next
// - First normal frame: prior mode, wake/fallback
// - Host restart or init: config register first
// - Automatic first answer clears nothing
// - Read-only clears selected register's interrupt bits
// - Read-only writes nothing, mode unchanged
// - Read-only counts as watchdog trigger
// - Read-only answers within same frame
// - Frames shift least significant bit first
// - Select 111 returns diagnostic readout word
module sdr_top (
  input wire logic i_clock,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial link from the host
  input wire logic i_csn,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // Device state and events
  input wire logic i_mode_change,
  input wire logic [2:0] i_prev_mode,
  input wire logic [2:0] i_new_mode,
  input wire logic i_restart_by_host,
  input wire logic i_restart_event,
  input wire logic [1:0] i_restart_cause,
  input wire logic i_fallback_event,
  input wire logic [2:0] i_fallback_cause,
  input wire logic i_fallback_off,
  input wire logic [2:0] i_strap_code,
  input wire logic i_wd_fail,
  input wire logic [7:0][9:0] i_reg_words,
  // Results toward the device
  output logic o_wr_valid,
  output sdr_pkg::sdr_frame_t o_wr_cmd,
  output logic o_rd_clear,
  output logic [2:0] o_rd_clear_sel,
  output logic o_wd_trigger,
  output logic o_sdm_active,
  output logic o_wd_restart_req,
  output logic o_irq
);
  import sdr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] link_level; // {csn, sclk, sdi}
  logic [2:0] link_rise;
  logic [2:0] link_fall;
  logic [2:0] strap_sync; // Strap pins after two flops

  sdr_link_sync #(.WIDTH(3), .RESET_VAL(`SDR_SYNC_RESET)) u_link_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_csn, i_sclk, i_sdi}),
    .o_level(link_level),
    .o_rise(link_rise),
    .o_fall(link_fall)
  );

  sdr_link_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_strap_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_strap_code),
    .o_level(strap_sync),
    .o_rise(),
    .o_fall()
  );

  wire csn_fall = link_fall[2]; // Frame start
  wire csn_rise = link_rise[2]; // Frame end
  wire sclk_rise = link_rise[1]; // Host samples on rise, so do we
  wire sclk_fall = link_fall[1]; // Output changes on fall
  wire sdi_bit = link_level[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sdr_link_state_t state_reg, state_next; // Link sequencer
  logic [15:0] rx_reg; // Incoming frame
  logic [15:0] tx_reg; // Outgoing frame
  logic [4:0] rx_cnt_reg; // Bits received
  logic [3:0] tx_idx_reg; // Bit now on the output
  logic sdo_reg; // Output data flop
  logic oe_reg; // Output enable flop
  logic [1:0] restart_reg, restart_next; // Restart cause
  logic [2:0] fallback_reg, fallback_next; // Fallback cause
  logic [2:0] strap_reg; // Strap capture
  logic [1:0] strap_done_reg; // Edges since release, stops when strap is held
  logic [2:0] cur_mode_reg; // Mode reported in mode bits
  logic [2:0] pend_sel_reg; // Select asked by previous command
  logic pend_auto_reg; // Pending answer was automatic
  logic ctrl_en_reg; // Link enable
  logic [3:0] irq_stat_reg, irq_en_reg;
  logic wr_valid_reg, rd_clear_reg, wd_trig_reg, wd_req_reg;
  logic [2:0] rd_clear_sel_reg;
  sdr_frame_t wr_cmd_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // Diagnostic word assembled from the three fields
  sdr_diag_t diag_word;
  assign diag_word = '{strap: strap_reg, fallback: fallback_reg, restart: restart_reg};

  // Register readback; select 111 is served here
  function automatic logic [9:0] sdr_pick(input logic [2:0] sel, input sdr_diag_t diag,
                                          input logic [7:0][9:0] words);
    sdr_pick = (sel == `SDR_SEL_DIAG) ? {2'h0, diag} : words[sel];
  endfunction : sdr_pick

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  sdr_frame_t rx_frame;
  assign rx_frame = rx_reg;
  wire is_ro = (rx_frame.mode == `SDR_MODE_READONLY);
  wire [2:0] early_mode = rx_reg[2:0];
  wire [2:0] early_sel = {sdi_bit, rx_reg[4:3]};
  wire ro_header = sclk_rise && (state_reg == SDR_SHIFT) && (rx_cnt_reg == `SDR_HDR_LAST_BIT)
                   && (early_mode == `SDR_MODE_READONLY);
  wire frame_start = csn_fall && ctrl_en_reg && (state_reg == SDR_IDLE);
  wire frame_ok = (state_reg == SDR_DONE);
  wire explicit_start = frame_start && !pend_auto_reg;
  wire [2:0] cmd_sel = rx_frame.sel;

  // Previous answer: mode bits, select, then requested data
  wire [15:0] resp_word = {sdr_pick(pend_sel_reg, diag_word, i_reg_words), pend_sel_reg, cur_mode_reg};

  // First-frame choice on entry to normal mode
  wire sdm = strap_reg[`SDR_STRAP_SDM_BIT];
  wire cfg13 = !sdm && !strap_reg[0]; // Configurations one and three
  wire enter_normal = i_mode_change && (i_new_mode == `SDR_MODE_NORMAL);
  wire [2:0] auto_sel = (i_prev_mode == `SDR_MODE_SLEEP) ? `SDR_SEL_WAKE :
                        (i_prev_mode == `SDR_MODE_FAILSAFE) ? `SDR_SEL_DIAG :
                        (i_prev_mode == `SDR_MODE_RESTART && !i_restart_by_host && cfg13) ?
                        `SDR_SEL_DIAG : `SDR_SEL_CONFIG;

  // Clear sources for the restart field
  wire leave_quiet = i_mode_change && (i_prev_mode == `SDR_MODE_SLEEP || i_prev_mode == `SDR_MODE_FAILSAFE);
  wire ro_diag_done = frame_ok && is_ro && (cmd_sel == `SDR_SEL_DIAG);
  wire nrm_diag_read = explicit_start && (pend_sel_reg == `SDR_SEL_DIAG);
  wire restart_clr = ro_diag_done || nrm_diag_read || leave_quiet;

  // ----------------------------------------------------------------
  // Diagnostic field next values, set wins over clear
  // ----------------------------------------------------------------
  always_comb
  begin
    restart_next = restart_reg;
    if (i_restart_event)
      restart_next = i_restart_cause;
    else if (restart_clr)
      restart_next = 2'h0;
    fallback_next = fallback_reg;
    if (i_fallback_event)
      fallback_next = i_fallback_cause;
    else if (i_fallback_off)
      fallback_next = 3'h0;
  end

  // Diagnostic registers and strap capture after reset release
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      restart_reg <= 2'h0;
      fallback_reg <= 3'h0;
      strap_reg <= 3'h0;
      strap_done_reg <= 2'h0;
    end
    else
    begin
      restart_reg <= restart_next;
      fallback_reg <= fallback_next;
      // Follows the synchroniser until it has filled, then holds; an earlier grab sees reset zeros
      if (strap_done_reg != `SDR_STRAP_WAIT)
      begin
        strap_done_reg <= strap_done_reg + 2'h1;
        strap_reg <= strap_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SDR_IDLE: if (frame_start) state_next = SDR_SHIFT;
      // Short frames return to idle, skipping the end-of-frame effects
      SDR_SHIFT: if (csn_rise) state_next = (rx_cnt_reg == `SDR_FRAME_BITS) ? SDR_DONE : SDR_IDLE;
      SDR_DONE: state_next = SDR_IDLE;
      default: state_next = SDR_IDLE;
    endcase
  end

  // Shift registers; both directions LSB first
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_reg <= SDR_IDLE;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      rx_cnt_reg <= 5'h00;
      tx_idx_reg <= 4'h0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      oe_reg <= (state_next == SDR_SHIFT);
      if (frame_start)
      begin
        tx_reg <= resp_word;
        sdo_reg <= resp_word[0];
        tx_idx_reg <= 4'h0;
        rx_cnt_reg <= 5'h00;
      end
      else if (state_reg == SDR_SHIFT)
      begin
        if (sclk_rise && rx_cnt_reg < `SDR_FRAME_BITS)
        begin
          rx_reg[rx_cnt_reg[3:0]] <= sdi_bit;
          rx_cnt_reg <= rx_cnt_reg + 5'h01;
        end
        // Data bits are still ahead on the wire when the header ends
        if (ro_header)
          tx_reg[15:`SDR_DATA_LSB] <= sdr_pick(early_sel, diag_word, i_reg_words);
        if (sclk_fall && tx_idx_reg != 4'hf)
        begin
          tx_idx_reg <= tx_idx_reg + 4'h1;
          sdo_reg <= tx_reg[tx_idx_reg + 4'h1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command effects
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cur_mode_reg <= `SDR_MODE_INIT;
      pend_sel_reg <= `SDR_SEL_CONFIG;
      pend_auto_reg <= 1'b1;
      wr_valid_reg <= 1'b0;
      wr_cmd_reg <= '0;
      rd_clear_reg <= 1'b0;
      rd_clear_sel_reg <= 3'h0;
      wd_trig_reg <= 1'b0;
      wd_req_reg <= 1'b0;
    end
    else
    begin
      wr_valid_reg <= frame_ok && !is_ro;
      wd_trig_reg <= frame_ok;
      wd_req_reg <= i_wd_fail && !sdm;
      rd_clear_reg <= (frame_ok && is_ro) || explicit_start;
      rd_clear_sel_reg <= (frame_ok && is_ro) ? cmd_sel : pend_sel_reg;
      if (frame_ok && !is_ro)
      begin
        wr_cmd_reg <= rx_frame;
        pend_sel_reg <= cmd_sel;
        pend_auto_reg <= 1'b0;
      end
      if (i_mode_change)
        cur_mode_reg <= i_new_mode;
      if (enter_normal)
      begin
        cur_mode_reg <= i_prev_mode;
        pend_sel_reg <= auto_sel;
        pend_auto_reg <= 1'b1;
      end
      else if (frame_start && pend_auto_reg)
        cur_mode_reg <= `SDR_MODE_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  wire apb_setup = i_psel && !i_penable;
  wire apb_write = i_psel && i_penable && i_pwrite;
  wire hit_ctrl = (i_paddr == `SDR_OFF_CTRL);
  wire hit_stat = (i_paddr == `SDR_OFF_STATUS);
  wire hit_irq_st = (i_paddr == `SDR_OFF_IRQ_STAT);
  wire hit_irq_clr = (i_paddr == `SDR_OFF_IRQ_CLR);
  wire hit_irq_en = (i_paddr == `SDR_OFF_IRQ_EN);
  wire hit_any = hit_ctrl | hit_stat | hit_irq_st | hit_irq_clr | hit_irq_en;
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_en_reg} :
                       hit_stat ? {14'h0, state_reg, pend_sel_reg, cur_mode_reg, 2'h0, diag_word} :
                       hit_irq_st ? {28'h0, irq_stat_reg} :
                       hit_irq_en ? {28'h0, irq_en_reg} : 32'h0;
  wire [3:0] irq_set = {i_fallback_event, i_restart_event, frame_ok && is_ro, frame_ok};
  wire [3:0] irq_clr = (apb_write && hit_irq_clr) ? i_pwdata[3:0] : 4'h0;

  // Bus registers; an event in the clear cycle survives
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ctrl_en_reg <= `SDR_CTRL_RESET;
      irq_en_reg <= `SDR_IRQ_EN_RESET;
      irq_stat_reg <= 4'h0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (apb_setup)
      begin
        prdata_reg <= i_pwrite ? 32'h0 : rd_mux;
        pslverr_reg <= !hit_any;
      end
      if (apb_write && hit_ctrl)
        ctrl_en_reg <= i_pwdata[0];
      if (apb_write && hit_irq_en)
        irq_en_reg <= i_pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_reg & i_psel & i_penable;
  assign o_sdo = sdo_reg;
  assign o_sdo_oe = oe_reg;
  assign o_wr_valid = wr_valid_reg;
  assign o_wr_cmd = wr_cmd_reg;
  assign o_rd_clear = rd_clear_reg;
  assign o_rd_clear_sel = rd_clear_sel_reg;
  assign o_wd_trigger = wd_trig_reg;
  assign o_sdm_active = sdm;
  assign o_wd_restart_req = wd_req_reg;
  assign o_irq = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ro_no_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (frame_ok && is_ro) |=> !o_wr_valid ##1 !o_wr_valid)
    else $error("read-only frame produced a write");
  ro_wd_trig_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (frame_ok && is_ro) |=> o_wd_trigger && o_rd_clear && o_rd_clear_sel == $past(cmd_sel))
    else $error("read-only frame missed trigger or clear");
  nrm_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (frame_ok && !is_ro) |=> o_wr_valid && o_wr_cmd == $past(rx_reg) && pend_sel_reg == $past(cmd_sel))
    else $error("normal frame not forwarded");
  restart_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_restart_event |=> restart_reg == $past(i_restart_cause))
    else $error("restart cause not recorded");
  quiet_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (leave_quiet && !i_restart_event) |=> restart_reg == 2'h0)
    else $error("restart cause kept after sleep or fail-safe");
  fb_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_fallback_off && !i_fallback_event) |=> fallback_reg == 3'h0)
    else $error("fallback cause kept after switch off");
  sdm_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_wd_fail && o_sdm_active) |=> !o_wd_restart_req)
    else $error("watchdog failure acted in development mode");
  sleep_first_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (enter_normal && i_prev_mode == `SDR_MODE_SLEEP) |=> pend_sel_reg == `SDR_SEL_WAKE
    && cur_mode_reg == `SDR_MODE_SLEEP && pend_auto_reg)
    else $error("first frame after sleep wrong");
  auto_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (frame_start && pend_auto_reg && !frame_ok) |=> !o_rd_clear && $stable(restart_reg[1:0]) || $past(i_restart_event)
    || $past(leave_quiet))
    else $error("automatic answer cleared status");
  ro_same_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ro_header |=> tx_reg[15:6] == $past(sdr_pick(early_sel, diag_word, i_reg_words)))
    else $error("read-only data not loaded in frame");
endmodule : sdr_top

//--- include/sdr_defines.svh
`ifndef SDR_DEFINES_SVH
`define SDR_DEFINES_SVH
// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define SDR_FRAME_BITS 5'd16
`define SDR_HDR_LAST_BIT 5'd5
`define SDR_DATA_LSB 6
// ----------------------------------------------------------------
// Mode select codes
// ----------------------------------------------------------------
`define SDR_MODE_INIT 3'h0
`define SDR_MODE_NORMAL 3'h1
`define SDR_MODE_SLEEP 3'h2
`define SDR_MODE_RESTART 3'h3
`define SDR_MODE_FAILSAFE 3'h4
`define SDR_MODE_FLASH 3'h5
`define SDR_MODE_READONLY 3'h7
// ----------------------------------------------------------------
// Configuration select codes
// ----------------------------------------------------------------
`define SDR_SEL_WAKE 3'h3
`define SDR_SEL_CONFIG 3'h4
`define SDR_SEL_DIAG 3'h7
// Strap bit that marks software development mode
`define SDR_STRAP_SDM_BIT 2
// ----------------------------------------------------------------
// APB map and reset values
// ----------------------------------------------------------------
`define SDR_OFF_CTRL 8'h00
`define SDR_OFF_STATUS 8'h04
`define SDR_OFF_IRQ_STAT 8'h08
`define SDR_OFF_IRQ_CLR 8'h0c
`define SDR_OFF_IRQ_EN 8'h10
`define SDR_CTRL_RESET 1'h1
`define SDR_IRQ_EN_RESET 4'h0
`define SDR_SYNC_RESET 3'h4
// Edges after reset release until the strap capture holds pin data
`define SDR_STRAP_WAIT 2'h3
// Interrupt status bit positions
`define SDR_IRQ_FRAME 0
`define SDR_IRQ_READONLY 1
`define SDR_IRQ_RESTART 2
`define SDR_IRQ_FALLBACK 3
`endif

//--- include/sdr_pkg.sv
package sdr_pkg;
  // One serial frame, mode bits shifted first
  typedef struct packed {
    logic [9:0] data;
    logic [2:0] sel;
    logic [2:0] mode;
  } sdr_frame_t;

  // Diagnostic readout word fields
  typedef struct packed {
    logic [2:0] strap;
    logic [2:0] fallback;
    logic [1:0] restart;
  } sdr_diag_t;

  // Link sequencer, Gray coded along idle-shift-done
  typedef enum logic [1:0] {
    SDR_IDLE = 2'b00,
    SDR_SHIFT = 2'b01,
    SDR_DONE = 2'b11
  } sdr_link_state_t;
endpackage : sdr_pkg

//--- verification/sdr_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host serial master model
// ----------------------------------------
module sdr_host_model (
  input wire logic i_clock,
  input wire logic i_sdo,
  output logic o_csn,
  output logic o_sclk,
  output logic o_sdi,
  output logic [15:0] o_resp
);
  // Idle: select high, clock parked low, data at pull-down level
  initial
  begin
    o_csn = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_resp = 16'h0000;
  end
  // One frame, 5 cycles a half period gives 80 ns
  task automatic xfer(input logic [15:0] cmd);
    @(posedge i_clock);
    o_csn <= 1'b0;
    repeat (4) @(posedge i_clock);
    for (int i = 0; i < 16; i++)
    begin
      o_sdi <= cmd[i]; // LSB first out
      repeat (5) @(posedge i_clock);
      o_sclk <= 1'b1;
      o_resp[i] <= i_sdo; // LSB first
      repeat (5) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
    repeat (5) @(posedge i_clock);
    o_csn <= 1'b1;
    o_sdi <= 1'b0; // Released line falls to pull-down
    repeat (10) @(posedge i_clock);
  endtask : xfer
endmodule : sdr_host_model

//--- verification/sdr_top_tb.sv
`timescale 1ns/10ps
`include "sdr_defines.svh"
module sdr_top_tb;
  import sdr_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic o_pready, o_pslverr, i_csn, i_sclk, i_sdi, o_sdo, o_sdo_oe, err;
  logic i_mode_change = 1'b0, i_restart_by_host = 1'b0, i_restart_event = 1'b0;
  logic [2:0] i_prev_mode = 3'h0, i_new_mode = 3'h0, i_fallback_cause = 3'h0;
  logic [1:0] i_restart_cause = 2'h0;
  logic i_fallback_event = 1'b0, i_fallback_off = 1'b0, i_wd_fail = 1'b0;
  logic [2:0] i_strap_code = 3'h6; // Development mode strap
  logic [7:0][9:0] i_reg_words;
  logic o_wr_valid, o_rd_clear, o_wd_trigger, o_sdm_active, o_wd_restart_req, o_irq;
  sdr_frame_t o_wr_cmd;
  logic [2:0] o_rd_clear_sel;
  logic [15:0] resp;
  int n_errors = 0, checks = 0, n_wr = 0, n_wd = 0, n_wdr = 0;
  int n_rdc = 0, n_oe = 0, mark = 0;
  logic [2:0] clr_sel = 3'h0; // Select of the latest clear pulse
  // Table rows: command, {check, expected response data}
  logic [15:0] row_cmd [7] = '{16'h0007, 16'h0037, 16'hffe9, 16'h0011, 16'h001f, 16'h0027, 16'h000f};
  logic [10:0] row_exp [7] = '{11'h6a0, 11'h6a6, 11'h000, 11'h6a5, 11'h6a3, 11'h6a4, 11'h6a1};
  always #4 i_clock = ~i_clock;
  sdr_top u_sdr_top (.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_csn, .i_sclk, .i_sdi, .o_sdo, .o_sdo_oe,
    .i_mode_change, .i_prev_mode, .i_new_mode, .i_restart_by_host, .i_restart_event,
    .i_restart_cause, .i_fallback_event, .i_fallback_cause, .i_fallback_off, .i_strap_code,
    .i_wd_fail, .i_reg_words, .o_wr_valid, .o_wr_cmd, .o_rd_clear, .o_rd_clear_sel,
    .o_wd_trigger, .o_sdm_active, .o_wd_restart_req, .o_irq);
  sdr_host_model u_sdr_host_model (.i_clock, .i_sdo(o_sdo), .o_csn(i_csn), .o_sclk(i_sclk),
    .o_sdi(i_sdi), .o_resp(resp));
  // Pulse counters on device outputs
  always @(posedge i_clock)
  begin
    n_wr += (o_wr_valid === 1'b1);
    n_wd += (o_wd_trigger === 1'b1);
    n_wdr += (o_wd_restart_req === 1'b1);
    n_rdc += (o_rd_clear === 1'b1);
    n_oe += (o_sdo_oe === 1'b1);
    if (o_rd_clear === 1'b1)
      clr_sel = o_rd_clear_sel;
  end
  // Readback word of each select code
  function automatic logic [9:0] w(input int i);
    return 10'h2a0 + 10'(i);
  endfunction : w
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1)
      n_errors++;
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic frame(input logic [15:0] cmd);
    u_sdr_host_model.xfer(cmd);
  endtask : frame
  // Mode change pulse from one mode to another
  task automatic mode(input logic [2:0] p, input logic [2:0] n);
    i_prev_mode <= p;
    i_new_mode <= n;
    i_mode_change <= 1'b1;
    @(posedge i_clock);
    i_mode_change <= 1'b0;
  endtask : mode
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Watchdog against a hang
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 8; i++)
      i_reg_words[i] = w(i);
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    apb(1'b0, `SDR_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h1, q);
    apb(1'b0, `SDR_OFF_STATUS, 32'h0);
    chk("diag fields", 8'hc0, q[7:0]);
    chk("sdm", 1'b1, o_sdm_active);
    i_wd_fail <= 1'b1;
    @(posedge i_clock);
    i_wd_fail <= 1'b0;
    apb(1'b1, `SDR_OFF_IRQ_EN, 32'h1);
    for (int r = 0; r < 7; r++)
    begin
      frame(row_cmd[r]);
      if (row_exp[r][10])
        chk("row data", row_exp[r][9:0], resp[15:6]);
      if (row_cmd[r][2:0] != `SDR_MODE_READONLY)
        chk("wr cmd", row_cmd[r], o_wr_cmd);
    end
    chk("wr count", 2, n_wr);
    chk("trigger count", 7, n_wd);
    chk("no wd restart", 0, n_wdr);
    chk("irq", 1'b1, o_irq);
    apb(1'b0, `SDR_OFF_IRQ_STAT, 32'h0);
    chk("irq frame bit", 1'b1, q[`SDR_IRQ_FRAME]);
    apb(1'b1, `SDR_OFF_IRQ_CLR, 32'hf);
    apb(1'b0, `SDR_OFF_IRQ_EN, 32'h0);
    chk("irq enable", 32'h1, q);
    chk("irq cleared", 1'b0, o_irq);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 1'b1, err);
    // Events recorded, then read and cleared
    i_restart_event <= 1'b1;
    i_restart_cause <= 2'h2;
    i_fallback_event <= 1'b1;
    i_fallback_cause <= 3'h5;
    @(posedge i_clock);
    i_restart_event <= 1'b0;
    i_fallback_event <= 1'b0;
    frame(16'h003f);
    chk("diag", 10'h0d6, resp[15:6]);
    chk("clear sel", `SDR_SEL_DIAG, clr_sel);
    frame(16'h003f);
    chk("restart read clear", 10'h0d4, resp[15:6]);
    i_fallback_off <= 1'b1;
    @(posedge i_clock);
    i_fallback_off <= 1'b0;
    frame(16'h003f);
    chk("fallback off", 10'h0c0, resp[15:6]);
    // Leaving sleep: first answer and restart clear
    i_restart_event <= 1'b1;
    i_restart_cause <= 2'h1;
    @(posedge i_clock);
    i_restart_event <= 1'b0;
    mode(`SDR_MODE_SLEEP, `SDR_MODE_NORMAL);
    mark = n_rdc;
    frame(16'h0001);
    chk("first mode", `SDR_MODE_SLEEP, resp[2:0]);
    chk("first sel", `SDR_SEL_WAKE, resp[5:3]);
    chk("first data", w(3), resp[15:6]);
    chk("auto no clear", mark, n_rdc);
    frame(16'h003f);
    chk("sleep exit clear", 10'h0c0, resp[15:6]);
    mode(`SDR_MODE_INIT, `SDR_MODE_NORMAL);
    frame(16'h0001);
    chk("init mode", `SDR_MODE_INIT, resp[2:0]);
    chk("init sel", `SDR_SEL_CONFIG, resp[5:3]);
    // Disabled link ignores frames
    apb(1'b1, `SDR_OFF_CTRL, 32'h0);
    mark = n_oe;
    frame(16'h0007);
    chk("disabled", 13, n_wd);
    chk("oe disabled", mark, n_oe);
    // Mid-run reset with a configuration strap, not development mode
    i_rst <= 1'b1;
    i_strap_code <= 3'h0;
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    chk("config strap", 1'b0, o_sdm_active);
    i_wd_fail <= 1'b1;
    @(posedge i_clock);
    i_wd_fail <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk("wd restart", 1, n_wdr);
    mode(`SDR_MODE_RESTART, `SDR_MODE_NORMAL);
    frame(16'h0001);
    chk("fail restart sel", `SDR_SEL_DIAG, resp[5:3]);
    i_restart_by_host <= 1'b1;
    mode(`SDR_MODE_RESTART, `SDR_MODE_NORMAL);
    frame(16'h0001);
    chk("host restart mode", `SDR_MODE_RESTART, resp[2:0]);
    chk("host restart sel", `SDR_SEL_CONFIG, resp[5:3]);
    mode(`SDR_MODE_FAILSAFE, `SDR_MODE_NORMAL);
    frame(16'h0001);
    chk("fail-safe mode", `SDR_MODE_FAILSAFE, resp[2:0]);
    chk("fail-safe sel", `SDR_SEL_DIAG, resp[5:3]);
    report_and_stop();
  end
endmodule : sdr_top_tb
